// ==== verilog/dse_encoder.sv ====
`timescale 1ns/1ps

// Summary of operation
// - With encoding enabled, each symbol is sent as a move of the state pointer, not a fixed state.
// - Each symbol looks up its signed offset in the table and moves the pointer by that amount.
// - An offset of +1 moves the pointer one position forward.
// - An offset of +2 moves the pointer two positions forward, as for data value 2 in the example.
// - An offset of -1 moves the pointer one position backward.
// - An offset of 0 keeps the pointer, so the same state is sent again.
// - Bits per symbol is the ceiling of log2 of the number of table entries, and at least one bit.
// - With two entries only the lowest data bit is used.
// - With four entries the two low bits select entries 0 to 3.
// - The default four-state map uses only the levels +1.0 and -1.0 on I and Q.
// - With encoding enabled, each output state depends on the pointer before it, starting from zero after reset or from the start state after a restart.
// - Equal data values always give equal moves wherever they appear in the stream.
// - The offset table acts only while encoding is enabled; otherwise data maps directly to states.
module dse_encoder
	import dse_pkg::*;
(
	// Clock and reset.
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_reset_n,
	// Configuration from the controlling logic.
	input  wire logic                    i_diff_en,
	input  wire logic [DSE_ENT_W-1:0]    i_num_entries,
	input  wire logic [DSE_ENT_W-1:0]    i_num_states,
	input  wire logic [DSE_PTR_W-1:0]    i_start_state,
	input  wire logic                    i_restart,
	// Offset table write port.
	input  wire logic                    i_ofs_we,
	input  wire logic [DSE_DATA_W-1:0]   i_ofs_addr,
	input  wire logic [DSE_OFS_W-1:0]    i_ofs_data,
	// State map write port.
	input  wire logic                    i_map_we,
	input  wire logic [DSE_PTR_W-1:0]    i_map_addr,
	input  wire logic [DSE_LVL_W-1:0]    i_map_i,
	input  wire logic [DSE_LVL_W-1:0]    i_map_q,
	// Symbol input stream.
	input  wire logic                    i_sym_valid,
	output logic                         o_sym_ready,
	input  wire logic [DSE_DATA_W-1:0]   i_sym_data,
	// Encoded I/Q output stream.
	output logic                         o_iq_valid,
	input  wire logic                    i_iq_ready,
	output logic [DSE_PTR_W-1:0]         o_iq_state,
	output logic [DSE_LVL_W-1:0]         o_iq_i,
	output logic [DSE_LVL_W-1:0]         o_iq_q,
	// Status.
	output logic [DSE_BPS_W-1:0]         o_bits_per_sym
);

	localparam int OUT_W = DSE_PTR_W + 2 * DSE_LVL_W;

	// Limitation: the offset remainder puts a divider in the next-state path,
	// which bounds the highest symbol clock. The map size is read every cycle,
	// so shrinking it mid-stream only affects later moves, and a pointer loaded
	// outside a smaller map is pulled back in by the next move.

	// ****************************************
	// Helper functions
	// ****************************************

	// Ceiling of log2 of a table size; one entry still uses one bit.
	function automatic logic [DSE_BPS_W-1:0] ceil_log2(input logic [DSE_ENT_W-1:0] n);
		logic [DSE_BPS_W-1:0] b;
		b = 4'h0;
		for (int k = 0; k < DSE_ENT_W; k++) begin
			if ((9'h001 << k) < n) begin
				b = 4'(k + 1);
			end
		end
		if (b == 4'h0) begin
			b = 4'h1;
		end
		return b;
	endfunction

	// Reduce a value modulo the map size; the size is never zero here.
	// A full remainder is needed: an offset may reach 128 steps in a tiny map.
	function automatic logic [DSE_ENT_W:0] wrap(input logic [DSE_ENT_W+1:0] v,
		input logic [DSE_ENT_W-1:0] m);
		logic [DSE_ENT_W+1:0] r;
		r = v % {2'h0, m};
		return r[DSE_ENT_W:0];
	endfunction

	// Default map level for one axis: a clear bit gives +1.0, a set bit -1.0.
	function automatic logic [DSE_LVL_W-1:0] map_level(input logic neg);
		return neg ? DSE_LVL_NEG : DSE_LVL_POS;
	endfunction

	// ****************************************
	// Tables
	// ****************************************
	// Offsets are signed two's complement bytes; levels are 16-bit words.
	logic [DSE_OFS_W-1:0]  ofs_mem [DSE_MAX_ENT];
	logic [DSE_LVL_W-1:0]  map_i_mem [DSE_MAP_MAX];
	logic [DSE_LVL_W-1:0]  map_q_mem [DSE_MAP_MAX];

	logic [DSE_PTR_W-1:0]  ptr_r;
	logic [DSE_PTR_W-1:0]  ptr_nxt;
	logic [DSE_BPS_W-1:0]  bps;
	logic [DSE_DATA_W-1:0] sym_idx;
	logic [DSE_ENT_W-1:0]  msize;
	logic [DSE_OFS_W-1:0]  ofs_raw;
	logic [DSE_OFS_W-1:0]  ofs_mag;
	logic [DSE_ENT_W:0]    ofs_red;
	logic [DSE_ENT_W+1:0]  mod_ofs;
	logic [DSE_ENT_W+1:0]  step_sum;
	logic                  buf_ready;
	logic                  take;
	logic [OUT_W-1:0]      out_word;

	// Offset table writes; reset clears every entry to a zero offset so an
	// unprogrammed data value repeats the current state.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int k = 0; k < DSE_MAX_ENT; k++) begin
				ofs_mem[k] <= DSE_OFS_RST;
			end
		end else if (i_ofs_we) begin
			ofs_mem[i_ofs_addr] <= i_ofs_data;
		end
	end

	// State map writes; reset repeats the four-state map over every entry.
	// default map levels
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int k = 0; k < DSE_MAP_MAX; k++) begin
				map_i_mem[k] <= map_level(k[0]);
				map_q_mem[k] <= map_level(k[1]);
			end
		end else if (i_map_we) begin
			map_i_mem[i_map_addr] <= i_map_i;
			map_q_mem[i_map_addr] <= i_map_q;
		end
	end

	// ****************************************
	// Symbol decode
	// ****************************************

	// Bits per symbol follow the table size, masking higher data bits.
	// A zero entry count reads as the four-entry default, so the mask is never empty.
	// bits per symbol
	assign bps = ceil_log2((i_num_entries == 9'h000) ? DSE_ENT_RST : i_num_entries);
	assign sym_idx = i_sym_data & 8'((9'h001 << bps) - 9'h001);
	assign o_bits_per_sym = bps;

	// Map size, guarded against zero or oversize settings.
	assign msize = ((i_num_states == 9'h000) || (i_num_states > 9'(DSE_MAP_MAX))) ?
		DSE_MAP_RST : i_num_states;

	// Offset reduced into 0..size-1 so a backward move becomes a forward wrap.
	// backward move
	assign ofs_raw = ofs_mem[sym_idx];
	assign ofs_mag = ofs_raw[DSE_OFS_W-1] ? (8'h00 - ofs_raw) : ofs_raw;
	assign ofs_red = wrap({3'h0, ofs_mag}, msize);

	// A negative offset steps forward by the size less its reduced magnitude.
	always_comb begin
		if (ofs_raw[DSE_OFS_W-1] && (ofs_red != 10'h000)) begin
			mod_ofs = {1'b0, {1'b0, msize} - ofs_red};
		end else begin
			mod_ofs = {1'b0, ofs_red};
		end
	end

	// Sum of the old pointer and the reduced offset; it fits without carry loss.
	assign step_sum = {3'h0, ptr_r} + mod_ofs;

	// Next pointer: direct mapping when disabled, relative move when enabled.
	// Both paths reduce modulo the map size, so the pointer stays inside the map.
	// mode select
	always_comb begin
		if (i_diff_en) begin
			ptr_nxt = 8'(wrap(step_sum, msize));
		end else begin
			ptr_nxt = 8'(wrap({3'h0, sym_idx}, msize));
		end
	end

	// ****************************************
	// Pointer state
	// ****************************************
	// Symbols are accepted whenever the output buffer has room.
	assign take = i_sym_valid && buf_ready;
	assign o_sym_ready = buf_ready;

	// Pointer resets to zero, loads the start state on restart and moves only on accepted symbols.
	// A restart wins over a symbol in the same cycle; the buffer drops that symbol
	// too while o_sym_ready stays high, so the pointer and the output stream stay in step.
	// history-based state
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ptr_r <= DSE_PTR_RST;
		end else if (i_restart) begin
			ptr_r <= i_start_state;
		end else if (take) begin
			ptr_r <= ptr_nxt;
		end
	end

	assign out_word = {ptr_nxt, map_i_mem[ptr_nxt], map_q_mem[ptr_nxt]};

	// Output buffer so a stalled receiver loses no state.
	// Each word carries the pointer after the move together with its two levels.
	dse_buf #(
		.W (OUT_W)
	) u_buf (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_valid   (i_sym_valid && !i_restart),
		.o_ready   (buf_ready),
		.i_data    (out_word),
		.o_valid   (o_iq_valid),
		.i_ready   (i_iq_ready),
		.o_data    ({o_iq_state, o_iq_i, o_iq_q})
	);

endmodule

// ==== verilog/dse_pkg.sv ====
package dse_pkg;

	// ****************************************
	// Table and map sizes
	// ****************************************
	localparam int          DSE_DATA_W      = 8;
	localparam int          DSE_OFS_W       = 8;
	localparam int          DSE_MAX_ENT     = 256;
	localparam int          DSE_ENT_W       = 9;
	localparam int          DSE_MAP_MAX     = 256;
	localparam int          DSE_PTR_W       = 8;
	localparam int          DSE_LVL_W       = 16;
	localparam int          DSE_BPS_W       = 4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [8:0]  DSE_ENT_RST     = 9'h004;
	localparam logic [8:0]  DSE_MAP_RST     = 9'h004;
	localparam logic [7:0]  DSE_PTR_RST     = 8'h00;
	localparam logic [7:0]  DSE_OFS_RST     = 8'h00;

	// ****************************************
	// Default four-state map levels
	// ****************************************
	localparam logic [15:0] DSE_LVL_POS     = 16'h4000;
	localparam logic [15:0] DSE_LVL_NEG     = 16'hC000;

	// ****************************************
	// Buffer
	// ****************************************
	localparam int          DSE_BUF_DEPTH   = 2;
	localparam int          DSE_BUF_AW      = 1;

endpackage

// ==== verilog/dse_buf.sv ====
`timescale 1ns/1ps

// Two-entry valid/ready buffer carrying one encoded output state.
module dse_buf
	import dse_pkg::*;
#(
	parameter int W = 40
) (
	// Clock and reset.
	input  wire logic         i_ref_clk,
	input  wire logic         i_reset_n,
	// Fill side.
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	// Drain side.
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic [W-1:0]      o_data
);

	logic [W-1:0]              mem_r [DSE_BUF_DEPTH];
	logic [DSE_BUF_AW-1:0]     wp_r;
	logic [DSE_BUF_AW-1:0]     rp_r;
	logic [DSE_BUF_AW:0]       cnt_r;
	logic                      push;
	logic                      pop;

	// Handshakes and honest full and empty.
	assign o_ready = (cnt_r != 2'(DSE_BUF_DEPTH));
	assign o_valid = (cnt_r != 2'h0);
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;
	assign o_data  = mem_r[rp_r];

	// Storage writes.
	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem_r[wp_r] <= i_data;
		end
	end

	// Pointers and occupancy.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wp_r  <= 1'h0;
			rp_r  <= 1'h0;
			cnt_r <= 2'h0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'h1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'h1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 2'h1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 2'h1;
			end
		end
	end

endmodule

// ==== verification/dse_encoder_properties.sv ====
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module dse_enc_chk
	import dse_pkg::*;
(
	// Watched ports.
	input wire logic        i_ref_clk,
	input wire logic        i_reset_n,
	input wire logic        i_diff_en,
	input wire logic [8:0]  i_num_entries,
	input wire logic [8:0]  i_num_states,
	input wire logic        i_restart,
	input wire logic        i_sym_valid,
	input wire logic        o_sym_ready,
	input wire logic [7:0]  i_sym_data,
	input wire logic        o_iq_valid,
	input wire logic        i_iq_ready,
	input wire logic [7:0]  o_iq_state,
	input wire logic [15:0] o_iq_i,
	input wire logic [15:0] o_iq_q,
	input wire logic [3:0]  o_bits_per_sym
);
	// Shared clock and reset for all checks.
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	// A symbol taken, and an output held back by the receiver.
	sequence s_take; i_sym_valid && o_sym_ready && !i_restart; endsequence
	sequence s_stall; o_iq_valid && !i_iq_ready; endsequence
	a_take_answer: assert property (s_take |=> o_iq_valid)
		else $error("taken symbol gave no output");
	a_full_pending: assert property (!o_sym_ready |-> o_iq_valid)
		else $error("refusal with nothing buffered");
	a_stall_holds: assert property (s_stall |=> o_iq_valid && $stable(o_iq_state))
		else $error("output changed under stall");
	a_restart_idle: assert property (i_restart && !o_iq_valid |=> !o_iq_valid)
		else $error("symbol taken during restart");
	a_direct_map: assert property ((s_take ##0 (!o_iq_valid && !i_diff_en && i_num_states == 9'h004
		&& i_num_entries == 9'h004)) |=> o_iq_state == ($past(i_sym_data) & 8'h03))
		else $error("direct map state wrong");
	a_level_i: assert property (o_iq_valid |-> o_iq_i == (o_iq_state[0] ? DSE_LVL_NEG : DSE_LVL_POS))
		else $error("I level wrong");
	a_level_q: assert property (o_iq_valid |-> o_iq_q == (o_iq_state[1] ? DSE_LVL_NEG : DSE_LVL_POS))
		else $error("Q level wrong");
	a_bps_two: assert property (i_num_entries == 9'h002 |-> o_bits_per_sym == 4'h1)
		else $error("two entries not one bit");
	a_bps_four: assert property (i_num_entries == 9'h004 |-> o_bits_per_sym == 4'h2)
		else $error("four entries not two bits");
	a_state_wrap: assert property (o_iq_valid && i_num_states == 9'h004 |-> o_iq_state < 8'h04)
		else $error("state outside map");
endmodule
bind dse_encoder dse_enc_chk u_chk (.i_ref_clk, .i_reset_n, .i_diff_en, .i_num_entries,
	.i_num_states, .i_restart, .i_sym_valid, .o_sym_ready, .i_sym_data, .o_iq_valid,
	.i_iq_ready, .o_iq_state, .o_iq_i, .o_iq_q, .o_bits_per_sym);

// ==== verification/dse_iq_sink.sv ====
`timescale 1ns/1ps
// ****************************************
// Downstream receiver model
// ****************************************
module dse_iq_sink (
	// Clock and reset.
	input  wire logic i_ref_clk,
	input  wire logic i_reset_n,
	// Handshake.
	input  wire logic i_stall,
	output logic      o_ready
);
	// Under stall the receiver takes a word only one cycle in four on average.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) o_ready <= 1'b0;
		else o_ready <= !i_stall || ($urandom() % 4 == 0);
	end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
	import dse_pkg::*;
	// ****************************************
	// Signals and model state
	// ****************************************
	logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_diff_en = 1'b1, i_restart = 1'b0;
	logic i_ofs_we = 1'b0, i_sym_valid = 1'b0, stall = 1'b0;
	logic o_sym_ready, o_iq_valid, i_iq_ready;
	logic [8:0] i_num_entries = 9'h004, i_num_states = 9'h004;
	logic [7:0] i_start_state = 8'h00, i_ofs_addr = 8'h00, i_ofs_data = 8'h00;
	logic [7:0] i_sym_data = 8'h00, o_iq_state;
	logic [15:0] o_iq_i, o_iq_q;
	logic [3:0] o_bits_per_sym;
	logic [7:0] exp_q[$];
	logic [7:0] st;
	logic [7:0] walk[5] = '{8'h00, 8'h03, 8'h02, 8'h00, 8'h01};
	int bad_count = 0, n_checks = 0, ptr = 0, ns = 4, bps = 2, ofs[256];
	int ents[11] = '{1, 2, 3, 4, 5, 8, 9, 16, 17, 256, 0};
	int bits[11] = '{1, 1, 2, 2, 3, 3, 4, 4, 5, 8, 2};
	always #50 i_ref_clk = ~i_ref_clk;
	dse_encoder uut (.i_ref_clk, .i_reset_n, .i_diff_en, .i_num_entries, .i_num_states,
		.i_start_state, .i_restart, .i_ofs_we, .i_ofs_addr, .i_ofs_data, .i_map_we(1'b0),
		.i_map_addr(8'h00), .i_map_i(16'h0000), .i_map_q(16'h0000), .i_sym_valid, .o_sym_ready,
		.i_sym_data, .o_iq_valid, .i_iq_ready, .o_iq_state, .o_iq_i, .o_iq_q, .o_bits_per_sym);
	dse_iq_sink u_sink (.i_ref_clk, .i_reset_n, .i_stall(stall), .o_ready(i_iq_ready));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(string what, logic [15:0] e, logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", what, e, s);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task stuck;
		chk("wait", 16'h0000, 16'h0001);
		report_and_stop();
	endtask
	task wofs(int a, int v);
		@(posedge i_ref_clk);
		i_ofs_we <= 1'b1;
		i_ofs_addr <= a[7:0];
		i_ofs_data <= v[7:0];
		ofs[a] = v;
		@(posedge i_ref_clk);
		i_ofs_we <= 1'b0;
	endtask
	task restart(int s);
		@(posedge i_ref_clk);
		i_restart <= 1'b1;
		i_start_state <= s[7:0];
		ptr = s;
		@(posedge i_ref_clk);
		i_restart <= 1'b0;
	endtask
	// The model moves its pointer at the edge where the symbol is taken.
	task send(logic [7:0] d);
		int k, sym;
		i_sym_valid <= 1'b1;
		i_sym_data <= d;
		for (k = 0; k < 60; k++) begin
			@(posedge i_ref_clk);
			if (o_sym_ready === 1'b1) break;
		end
		if (k == 60) stuck();
		sym = d & ((1 << bps) - 1);
		ptr = i_diff_en ? (((ptr + ofs[sym]) % ns) + ns) % ns : sym % ns;
		exp_q.push_back(ptr[7:0]);
	endtask
	task flush(string name);
		int k;
		i_sym_valid <= 1'b0;
		for (k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge i_ref_clk);
		if (exp_q.size() > 0) stuck();
		$display("test %s done", name);
	endtask
	// Every word the receiver takes is compared with the model.
	always @(posedge i_ref_clk) begin
		if (i_reset_n && o_iq_valid === 1'b1 && i_iq_ready === 1'b1) begin
			if (exp_q.size() == 0) chk("extra", 16'h0000, 16'h0001);
			else begin
				st = exp_q.pop_front();
				chk("state", st, o_iq_state);
				chk("level_i", st[0] ? DSE_LVL_NEG : DSE_LVL_POS, o_iq_i);
				chk("level_q", st[1] ? DSE_LVL_NEG : DSE_LVL_POS, o_iq_q);
			end
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(86));
		repeat (12) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		wofs(0, 1);
		wofs(1, -1);
		wofs(2, 2);
		wofs(3, 0);
		restart(0);
		foreach (walk[i]) send({6'($urandom()), walk[i][1:0]});
		flush("walk");
		stall <= 1'b1;
		i_num_states <= 9'h008;
		ns = 8;
		restart(7);
		repeat (40) send(8'($urandom()));
		flush("stall");
		stall <= 1'b0;
		i_diff_en <= 1'b0;
		i_num_states <= 9'h004;
		ns = 4;
		repeat (20) send(8'($urandom()));
		flush("direct");
		i_diff_en <= 1'b1;
		i_num_entries <= 9'h002;
		bps = 1;
		restart(1);
		repeat (20) send(8'($urandom()));
		flush("one_bit");
		i_num_entries <= 9'h004;
		i_num_states <= 9'h005;
		bps = 2;
		ns = 5;
		for (int a = 0; a < 4; a++) wofs(a, int'($urandom_range(255)) - 128);
		restart(3);
		repeat (30) send(8'($urandom()));
		flush("wide");
		foreach (ents[i]) begin
			i_num_entries <= ents[i][8:0];
			@(posedge i_ref_clk);
			chk("bps", 16'(bits[i]), {12'h000, o_bits_per_sym});
		end
		$display("test bits done");
		report_and_stop();
	end
endmodule
